// ---- include/wr_burst_pkg.sv ----
// Shared constants and types of the write burst timing block
package wr_burst_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int BG_W = 2;
    localparam int BA_W = 2;
    localparam int COL_W = 10;
    localparam int NBANK = 16;
    localparam int DQ_W = 8;
    localparam int LAT_W = 6;
    localparam int MAX_LAT = 64;
    localparam int WR_W = 5;
    localparam int GAP_W = 4;

    // ----------------------------------------
    // Burst field codes of mode_register_zero
    // ----------------------------------------
    localparam logic [1:0] BURST_FIXED_8 = 2'h0;
    localparam logic [1:0] BURST_ON_FLY = 2'h1;
    localparam logic [1:0] BURST_FIXED_4 = 2'h2;

    // ----------------------------------------
    // Burst shape: two beats per clock
    // ----------------------------------------
    localparam logic [1:0] LAST_IDX_FULL = 2'h3;
    localparam logic [1:0] LAST_IDX_CHOP = 2'h1;
    localparam logic [1:0] CHOP_LIMIT = 2'h2;

    // ----------------------------------------
    // Latency and spacing checks
    // ----------------------------------------
    localparam logic [4:0] CWL_LOWEST = 5'h09;
    localparam logic [GAP_W-1:0] GAP_FORBID_CRC = 4'h6;
    localparam logic [GAP_W-1:0] GAP_FORBID_NOCRC = 4'h5;
    localparam logic [GAP_W-1:0] GAP_SAT = 4'hF;
    localparam logic [GAP_W-1:0] GAP_START = 4'h1;
    localparam logic [LAT_W-1:0] LAT_MIN = 6'h01;
    localparam logic [WR_W-1:0] WR_MIN = 5'h01;

    typedef struct packed {
        logic [BG_W-1:0] bg;
        logic [BA_W-1:0] ba;
        logic [COL_W-1:0] col;
        logic chop;
        logic auto_pre;
    } wr_desc_t;

    typedef struct packed {
        logic valid;
        wr_desc_t desc;
    } wr_slot_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BURST = 1'b1
    } eng_state_t;

endpackage

// ---- core/wr_latency_line.sv ----
// Delay line that holds accepted writes until their data is due
`timescale 1ns/1ns
module wr_latency_line (
    input wire logic clk,
    input wire logic rst,
    input wire wr_burst_pkg::wr_slot_t slot_in,
    input wire logic [wr_burst_pkg::LAT_W-1:0] lat,
    output wr_burst_pkg::wr_slot_t slot_out
);
    wr_burst_pkg::wr_slot_t stage_ff [wr_burst_pkg::MAX_LAT];

    // ----------------------------------------
    // Shift one stage per clock
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < wr_burst_pkg::MAX_LAT; i++) begin
                stage_ff[i] <= '0;
            end
        end else begin
            stage_ff[0] <= slot_in;
            for (int i = 1; i < wr_burst_pkg::MAX_LAT; i++) begin
                stage_ff[i] <= stage_ff[i-1];
            end
        end
    end

    // Stage lat-1 is seen exactly lat clocks after the command
    assign slot_out = stage_ff[lat - wr_burst_pkg::LAT_MIN];
endmodule

// ---- core/wr_burst_timing.sv ----
// Write burst engine: burst length, data latency, auto precharge timing
//
// Function
// [RULE_01] Full eight-beat burst: fixed mode or A12 high
// [RULE_02] On-the-fly with A12 low gives chopped four
// [RULE_03] Fixed chop mode always writes four beats
// [RULE_04] Each write's burst length chosen independently
// [RULE_05] Timing measured from edge after last beat
// [RULE_06] Host waits recovery before explicit precharge
// [RULE_07] Auto precharge starts after recovery from data
// [RULE_08] Host honours long write-to-read in group
// [RULE_09] Inversion on, CRC off: inversion recovery times
// [RULE_10] CRC plus mask: their own recovery times
// [RULE_11] Two-clock preamble with CRC: no six-clock spacing
// [RULE_12] Two-clock preamble forbids lowest write latency
// [RULE_13] Deselect slots may carry other commands
// [RULE_14] Two-clock preamble without CRC: no five spacing
// [RULE_15] First beat at AL plus CWL plus PL
// [RULE_16] Chopped burst leaves second-half columns untouched
`timescale 1ns/1ns
module wr_burst_timing (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CMD_WRITE,
    input wire logic CMD_AUTO_PRE,
    input wire logic CMD_BURST_SEL,
    input wire logic [wr_burst_pkg::BG_W-1:0] CMD_BG,
    input wire logic [wr_burst_pkg::BA_W-1:0] CMD_BA,
    input wire logic [wr_burst_pkg::COL_W-1:0] CMD_COL,
    input wire logic [1:0] BURST_MODE,
    input wire logic [4:0] ADD_LAT,
    input wire logic [4:0] WRITE_LAT,
    input wire logic [2:0] PAR_LAT,
    input wire logic PARITY_EN,
    input wire logic PREAMBLE_2CK,
    input wire logic DBI_EN,
    input wire logic CRC_EN,
    input wire logic DM_EN,
    input wire logic [wr_burst_pkg::WR_W-1:0] WRITE_RECOVERY,
    input wire logic [wr_burst_pkg::WR_W-1:0] WRITE_RECOVERY_WITH_INVERSION,
    input wire logic [wr_burst_pkg::WR_W-1:0] WRITE_RECOVERY_WITH_CRC_AND_MASK,
    input wire logic [2*wr_burst_pkg::DQ_W-1:0] DQ_IN,
    input wire logic [1:0] DM_IN,
    output logic MEM_WE,
    output logic [wr_burst_pkg::BG_W-1:0] MEM_BG,
    output logic [wr_burst_pkg::BA_W-1:0] MEM_BA,
    output logic [wr_burst_pkg::COL_W-1:0] MEM_COL,
    output logic [2*wr_burst_pkg::DQ_W-1:0] MEM_WDATA,
    output logic [1:0] MEM_BYTE_EN,
    output logic LAST_DATA_EDGE,
    output logic [wr_burst_pkg::NBANK-1:0] PRECHARGE_BANKS,
    output logic BURST_BUSY,
    output logic CWL_CFG_ERR,
    output logic SPACING_ERR
);
    wr_burst_pkg::wr_slot_t cmd_slot;
    wr_burst_pkg::wr_slot_t due_slot;
    wr_burst_pkg::wr_desc_t cur_desc;
    wr_burst_pkg::wr_desc_t desc_ff;
    wr_burst_pkg::eng_state_t state_ff;
    wr_burst_pkg::eng_state_t nxt_state;
    logic [1:0] idx_ff;
    logic [1:0] cur_idx;
    logic [1:0] last_idx;
    logic cur_active;
    logic cur_last;
    logic cmd_chop;
    logic [wr_burst_pkg::LAT_W-1:0] lat_sum;
    logic [wr_burst_pkg::LAT_W-1:0] lat;
    logic [wr_burst_pkg::WR_W-1:0] wr_sel;
    logic [wr_burst_pkg::WR_W-1:0] wr_load;
    logic [wr_burst_pkg::GAP_W-1:0] gap_ff;
    logic [wr_burst_pkg::NBANK-1:0] pre_fire;
    logic ap_done;

    // ----------------------------------------
    // Command capture
    // ----------------------------------------
    // Only a write is looked at; any other command in a deselect slot passes by
    always_comb begin
        unique case (BURST_MODE)
            wr_burst_pkg::BURST_FIXED_8: cmd_chop = 1'b0;  // see [RULE_01]
            wr_burst_pkg::BURST_ON_FLY: cmd_chop = ~CMD_BURST_SEL;  // see [RULE_02]
            wr_burst_pkg::BURST_FIXED_4: cmd_chop = 1'b1;  // see [RULE_03]
            default: cmd_chop = 1'b0;
        endcase
        cmd_slot.valid = CMD_WRITE;  // see [RULE_13]
        cmd_slot.desc.bg = CMD_BG;
        cmd_slot.desc.ba = CMD_BA;
        cmd_slot.desc.col = CMD_COL;
        cmd_slot.desc.chop = cmd_chop;  // see [RULE_04]
        cmd_slot.desc.auto_pre = CMD_AUTO_PRE;
    end

    // Out-of-range sums wrap; the host keeps the total inside the line depth
    always_comb begin
        lat_sum = {1'h0, ADD_LAT} + {1'h0, WRITE_LAT}
            + (PARITY_EN ? {3'h0, PAR_LAT} : 6'h00);  // see [RULE_15]
        lat = (lat_sum == '0) ? wr_burst_pkg::LAT_MIN : lat_sum;
    end

    wr_latency_line u_line (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .slot_in(cmd_slot),
        .lat(lat),
        .slot_out(due_slot)
    );

    // ----------------------------------------
    // Data beat engine
    // ----------------------------------------
    // A new due write takes over at once, giving gapless back-to-back bursts
    always_comb begin
        cur_active = due_slot.valid || (state_ff == wr_burst_pkg::ST_BURST);
        cur_desc = due_slot.valid ? due_slot.desc : desc_ff;
        cur_idx = due_slot.valid ? 2'h0 : idx_ff;
        last_idx = cur_desc.chop ? wr_burst_pkg::LAST_IDX_CHOP
            : wr_burst_pkg::LAST_IDX_FULL;
        cur_last = cur_active && (cur_idx == last_idx);  // see [RULE_05]
        nxt_state = (cur_active && !cur_last) ? wr_burst_pkg::ST_BURST
            : wr_burst_pkg::ST_IDLE;
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state_ff <= wr_burst_pkg::ST_IDLE;
            idx_ff <= 2'h0;
            desc_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= cur_idx + 2'h1;
            desc_ff <= cur_desc;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            MEM_WE <= 1'b0;
            MEM_BG <= '0;
            MEM_BA <= '0;
            MEM_COL <= '0;
            MEM_WDATA <= '0;
            MEM_BYTE_EN <= 2'h0;
            BURST_BUSY <= 1'b0;
            LAST_DATA_EDGE <= 1'b0;
        end else begin
            // Chopped burst never writes beats four to seven
            MEM_WE <= cur_active
                && (!cur_desc.chop || cur_idx < wr_burst_pkg::CHOP_LIMIT);  // see [RULE_16]
            MEM_BG <= cur_desc.bg;
            MEM_BA <= cur_desc.ba;
            MEM_COL <= cur_desc.col + {{(wr_burst_pkg::COL_W-3){1'b0}}, cur_idx, 1'b0};
            MEM_WDATA <= DQ_IN;
            MEM_BYTE_EN <= (DM_EN && !DBI_EN) ? ~DM_IN : 2'h3;
            BURST_BUSY <= nxt_state == wr_burst_pkg::ST_BURST;
            LAST_DATA_EDGE <= cur_last;  // see [RULE_05]
        end
    end

    // ----------------------------------------
    // Auto precharge recovery
    // ----------------------------------------
    always_comb begin
        if (CRC_EN && DM_EN) begin
            wr_sel = WRITE_RECOVERY_WITH_CRC_AND_MASK;  // see [RULE_10]
        end else if (DBI_EN && !CRC_EN) begin
            wr_sel = WRITE_RECOVERY_WITH_INVERSION;  // see [RULE_09]
        end else begin
            wr_sel = WRITE_RECOVERY;
        end
        wr_load = (wr_sel < wr_burst_pkg::WR_MIN) ? wr_burst_pkg::WR_MIN : wr_sel;
        ap_done = cur_last && cur_desc.auto_pre;
    end

    // One counter per bank, so auto precharges to different banks overlap
    for (genvar b = 0; b < wr_burst_pkg::NBANK; b++) begin : g_bank
        logic [wr_burst_pkg::WR_W-1:0] rec_ff;
        logic hit;
        assign hit = ap_done && ({cur_desc.bg, cur_desc.ba} == 4'(b));
        assign pre_fire[b] = !hit && (rec_ff == wr_burst_pkg::WR_MIN);

        always_ff @(posedge REF_CLK) begin
            if (SYS_RST) begin
                rec_ff <= '0;
            end else if (hit) begin
                rec_ff <= wr_load;  // see [RULE_07]
            end else if (rec_ff != '0) begin
                rec_ff <= rec_ff - wr_burst_pkg::WR_MIN;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            PRECHARGE_BANKS <= '0;
        end else begin
            PRECHARGE_BANKS <= pre_fire;  // see [RULE_07]
        end
    end

    // ----------------------------------------
    // Host misuse checks
    // ----------------------------------------
    // The device cannot stop a bad host; it only reports what it saw
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            gap_ff <= wr_burst_pkg::GAP_SAT;
        end else if (CMD_WRITE) begin
            gap_ff <= wr_burst_pkg::GAP_START;
        end else if (gap_ff != wr_burst_pkg::GAP_SAT) begin
            gap_ff <= gap_ff + wr_burst_pkg::GAP_START;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            SPACING_ERR <= 1'b0;
            CWL_CFG_ERR <= 1'b0;
        end else begin
            SPACING_ERR <= CMD_WRITE && PREAMBLE_2CK && (CRC_EN
                ? gap_ff == wr_burst_pkg::GAP_FORBID_CRC  // see [RULE_11]
                : gap_ff == wr_burst_pkg::GAP_FORBID_NOCRC);  // see [RULE_14]
            CWL_CFG_ERR <= PREAMBLE_2CK
                && (WRITE_LAT <= wr_burst_pkg::CWL_LOWEST);  // see [RULE_12]
        end
    end
endmodule

// ---- tb/wr_ctrl_model.sv ----
// Controller-side source for the write data and mask lanes
`timescale 1ns/1ns
module wr_ctrl_model (
    input wire logic clk,
    output logic [15:0] dq = 16'h0000,
    output logic [1:0] dm = 2'h0
);
    int cyc = 0;
    // Lanes change every clock, so an early or late capture never matches
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge clk) begin
        dq <= {cyc[7:0] ^ 8'hA5, cyc[7:0]};
        dm <= cyc[1:0];
    end
endmodule

// ---- tb/wr_burst_timing_checker.sv ----
// Port assertions for the write burst engine
`timescale 1ns/1ns
module wr_burst_timing_checker (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CMD_WRITE,
    input wire logic [4:0] ADD_LAT,
    input wire logic [4:0] WRITE_LAT,
    input wire logic [2:0] PAR_LAT,
    input wire logic PARITY_EN,
    input wire logic PREAMBLE_2CK,
    input wire logic DBI_EN,
    input wire logic CRC_EN,
    input wire logic DM_EN,
    input wire logic [4:0] WRITE_RECOVERY,
    input wire logic [4:0] WRITE_RECOVERY_WITH_INVERSION,
    input wire logic [4:0] WRITE_RECOVERY_WITH_CRC_AND_MASK,
    input wire logic MEM_WE,
    input wire logic LAST_DATA_EDGE,
    input wire logic BURST_BUSY,
    input wire logic [15:0] PRECHARGE_BANKS,
    input wire logic CWL_CFG_ERR,
    input wire logic SPACING_ERR
);
    // ----
    // Helper history
    // ----
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    logic [63:0] hist_ff;
    logic [3:0] gap_ff;
    logic [4:0] age_ff, rec;
    logic [5:0] lat;
    logic bad;
    logic cwl_bad;
    assign lat = 6'(ADD_LAT) + 6'(WRITE_LAT) + (PARITY_EN ? 6'(PAR_LAT) : 6'h00);
    assign rec = (CRC_EN && DM_EN) ? WRITE_RECOVERY_WITH_CRC_AND_MASK
        : (DBI_EN && !CRC_EN) ? WRITE_RECOVERY_WITH_INVERSION : WRITE_RECOVERY;
    assign bad = CMD_WRITE && PREAMBLE_2CK && gap_ff == (CRC_EN ? 4'h6 : 4'h5);
    assign cwl_bad = PREAMBLE_2CK && WRITE_LAT <= 5'h09;
    always_ff @(posedge REF_CLK) begin
        hist_ff <= SYS_RST ? 64'h0 : {hist_ff[62:0], CMD_WRITE};
    end
    // Saturating so an old write never aliases a forbidden spacing
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || CMD_WRITE) gap_ff <= SYS_RST ? 4'hF : 4'h1;
        else if (gap_ff != 4'hF) gap_ff <= gap_ff + 4'h1;
    end
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || LAST_DATA_EDGE) age_ff <= SYS_RST ? 5'h1F : 5'h01;
        else if (age_ff != 5'h1F) age_ff <= age_ff + 5'h01;
    end
    // ----
    // Assertions
    // ----
    sequence burst_start_s;
        MEM_WE && !$past(MEM_WE);
    endsequence
    first_beat_a: assert property (hist_ff[lat] |-> MEM_WE)
        else $error("write data not taken at its latency");
    start_cause_a: assert property (burst_start_s |-> hist_ff[lat])
        else $error("burst started with no write at its latency");
    we_end_a: assert property ($fell(MEM_WE) |-> $past(LAST_DATA_EDGE))
        else $error("burst ended without last data edge");
    last_edge_a: assert property (LAST_DATA_EDGE |-> MEM_WE)
        else $error("last data edge outside a data clock");
    busy_level_a: assert property (BURST_BUSY == (MEM_WE && !LAST_DATA_EDGE))
        else $error("busy level disagrees with the data clocks");
    precharge_a: assert property (|PRECHARGE_BANKS |-> age_ff == rec)
        else $error("auto precharge not at recovery time");
    gap_flag_a: assert property (bad |=> SPACING_ERR)
        else $error("forbidden write spacing not flagged");
    gap_only_a: assert property (SPACING_ERR |-> $past(bad))
        else $error("spacing flag without forbidden spacing");
    cwl_err_a: assert property (!$past(SYS_RST) |->
        CWL_CFG_ERR == $past(cwl_bad))
        else $error("latency config flag wrong");
endmodule
bind wr_burst_timing wr_burst_timing_checker chk (
    .REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST),
    .CMD_WRITE(CMD_WRITE),
    .ADD_LAT(ADD_LAT),
    .WRITE_LAT(WRITE_LAT),
    .PAR_LAT(PAR_LAT),
    .PARITY_EN(PARITY_EN),
    .PREAMBLE_2CK(PREAMBLE_2CK),
    .DBI_EN(DBI_EN),
    .CRC_EN(CRC_EN),
    .DM_EN(DM_EN),
    .WRITE_RECOVERY(WRITE_RECOVERY),
    .WRITE_RECOVERY_WITH_INVERSION(WRITE_RECOVERY_WITH_INVERSION),
    .WRITE_RECOVERY_WITH_CRC_AND_MASK(WRITE_RECOVERY_WITH_CRC_AND_MASK),
    .MEM_WE(MEM_WE),
    .LAST_DATA_EDGE(LAST_DATA_EDGE),
    .BURST_BUSY(BURST_BUSY),
    .PRECHARGE_BANKS(PRECHARGE_BANKS),
    .CWL_CFG_ERR(CWL_CFG_ERR),
    .SPACING_ERR(SPACING_ERR)
);

// ---- tb/wr_burst_timing_tb.sv ----
// Self-checking bench for the write burst engine
`timescale 1ns/1ns
module wr_burst_timing_tb;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, ap = 1'b0, sel = 1'b0;
    logic pe = 1'b0, pre2 = 1'b0, dbi = 1'b0, crc = 1'b0, dm = 1'b0;
    logic [1:0] bg = 2'h0, ba = 2'h1, mode = 2'h0, mbg, mba, mbe, dmi;
    logic [9:0] col = 10'h000, mcol;
    logic [4:0] al = 5'h00, cwl = 5'h09, r0 = 5'h0C, r1 = 5'h0E, r2 = 5'h10;
    logic [2:0] pl = 3'h4;
    logic [15:0] dq, mdat, pch;
    logic mwe, lde, cerr, serr;
    int errors = 0, n_compared = 0, cyc = 0, e0, t;
    logic [47:0] we_q[$];
    int lde_q[$], pch_q[$];
    wr_ctrl_model ctl (.clk(clk), .dq(dq), .dm(dmi));
    wr_burst_timing dut (.REF_CLK(clk), .SYS_RST(rst), .CMD_WRITE(we), .CMD_AUTO_PRE(ap),
        .CMD_BURST_SEL(sel), .CMD_BG(bg), .CMD_BA(ba), .CMD_COL(col), .BURST_MODE(mode),
        .ADD_LAT(al), .WRITE_LAT(cwl), .PAR_LAT(pl), .PARITY_EN(pe), .PREAMBLE_2CK(pre2),
        .DBI_EN(dbi), .CRC_EN(crc), .DM_EN(dm), .WRITE_RECOVERY(r0),
        .WRITE_RECOVERY_WITH_INVERSION(r1), .WRITE_RECOVERY_WITH_CRC_AND_MASK(r2),
        .DQ_IN(dq), .DM_IN(dmi), .MEM_WE(mwe), .MEM_BG(mbg), .MEM_BA(mba), .MEM_COL(mcol),
        .MEM_WDATA(mdat), .MEM_BYTE_EN(mbe), .LAST_DATA_EDGE(lde), .PRECHARGE_BANKS(pch),
        .BURST_BUSY(), .CWL_CFG_ERR(cerr), .SPACING_ERR(serr));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge clk) begin
        if (mwe) we_q.push_back({16'(cyc), mbg, mba, mcol, mdat, mbe});
        if (lde) lde_q.push_back(cyc);
        if (pch != 16'h0000) pch_q.push_back({16'(cyc), pch});
    end
    // ----
    // Access tasks
    // ----
    function automatic int lat();
        return al + cwl + (pe ? pl : 3'h0);
    endfunction
    task automatic chk(input string what, input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic s, input logic a, input logic [1:0] g, input logic [9:0] c);
        @(negedge clk);
        {we, sel, ap, bg, col} = {1'b1, s, a, g, c};
        e0 = cyc + 1;
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic burst(input int t0, input int n, input logic [9:0] c, input logic [1:0] g);
        int m, d;
        for (int k = 0; k < n; k++) begin
            m = t0 + lat() + k;
            d = m - 1;
            chk("beat", we_q.size() ? we_q.pop_front() : 48'h0, {16'(m), g, ba,
                c + 10'(2 * k), d[7:0] ^ 8'hA5, d[7:0], (dm && !dbi) ? ~d[1:0] : 2'h3});
        end
    endtask
    task automatic one(input string nm, input logic s, input logic a, input int n);
        int r;
        r = (crc && dm) ? r2 : (dbi && !crc) ? r1 : r0;
        wr(s, a, 2'h2, 10'h040);
        // Next command only after recovery has long run out
        repeat (70) @(negedge clk);
        burst(e0, n, 10'h040, 2'h2);
        chk("extra beats", 48'(we_q.size()), 48'h0);
        chk("last edge", 48'(lde_q.size() == 1 ? lde_q[0] : 0),
            48'(e0 + lat() + n - 1));
        chk("precharge", 48'(pch_q.size() == 1 ? pch_q[0] : 0),
            a ? {16'(e0 + lat() + n - 1 + r), 16'h0200} : 48'h0);
        lde_q.delete();
        pch_q.delete();
        $display("test %s done", nm);
    endtask
    task automatic gap(input int k, input logic bad);
        wr(1'b1, 1'b0, 2'h1, 10'h000);
        repeat (k - 2) @(negedge clk);
        wr(1'b1, 1'b0, 2'h2, 10'h008);
        chk("spacing flag", 48'(serr), 48'(bad));
        repeat (70) @(negedge clk);
        we_q.delete();
        lde_q.delete();
        $display("test spacing %0d done", k);
    endtask
    task automatic results();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----
    // Test sequence
    // ----
    initial begin
        #2000000;
        errors++;
        results();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        one("fixed eight", 1'b0, 1'b0, 4);
        mode = 2'h1;
        one("fly eight", 1'b1, 1'b0, 4);
        one("fly chop", 1'b0, 1'b0, 2);
        mode = 2'h2;
        one("fixed chop", 1'b1, 1'b0, 2);
        // Spare burst code behaves as fixed eight
        mode = 2'h3;
        one("spare code", 1'b0, 1'b0, 4);
        mode = 2'h0;
        one("auto precharge", 1'b0, 1'b1, 4);
        dbi = 1'b1;
        one("inversion recovery", 1'b0, 1'b1, 4);
        {dbi, crc, dm, mode} = {3'b011, 2'h1};
        one("crc mask recovery", 1'b0, 1'b1, 2);
        {crc, dm, al, cwl, pe} = {2'b00, 5'h02, 5'h0A, 1'b1};
        one("parity latency", 1'b1, 1'b0, 4);
        {al, cwl, pe} = {5'h00, 5'h09, 1'b0};
        repeat (70) @(negedge clk);
        wr(1'b1, 1'b0, 2'h0, 10'h100);
        t = e0;
        repeat (2) @(negedge clk);
        wr(1'b0, 1'b0, 2'h3, 10'h200);
        // No read or precharge until write-to-read has run out
        repeat (70) @(negedge clk);
        chk("mixed beat count", 48'(we_q.size()), 48'h6);
        chk("mixed last edges", 48'(lde_q.size()), 48'h2);
        burst(t, 4, 10'h100, 2'h0);
        burst(e0, 2, 10'h200, 2'h3);
        chk("extra beats", 48'(we_q.size()), 48'h0);
        lde_q.delete();
        $display("test mixed back to back done");
        pre2 = 1'b1;
        @(negedge clk);
        chk("latency config", 48'(cerr), 48'h1);
        cwl = 5'h0A;
        @(negedge clk);
        chk("latency config", 48'(cerr), 48'h0);
        gap(5, 1'b1);
        gap(4, 1'b0);
        crc = 1'b1;
        gap(6, 1'b1);
        gap(5, 1'b0);
        results();
    end
endmodule
